/* File: include/swc_pkg.sv */
// Shared constants and types for the sleep and wake controller.
// Assumes a single core clock; register bus is byte wide with a 4-bit address.
package swc_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// Register offsets.
	localparam logic [3:0] REG_STATUS    = 4'h0;
	localparam logic [3:0] REG_FLAGS4    = 4'h1;
	localparam logic [3:0] REG_ENABLE4   = 4'h2;
	localparam logic [3:0] REG_CTRL      = 4'h3;
	localparam logic [3:0] REG_WDT_LIMIT = 4'h4;

	// Field positions.
	localparam int BIT_EXPIRY    = 4;
	localparam int BIT_PWRDN     = 3;
	localparam int BIT_BUS_COLL  = 1;
	localparam int BIT_SERIAL    = 0;
	localparam int CTRL_SLEEP_RUN = 0;
	localparam int CTRL_WDT_EN   = 1;
	localparam int CTRL_OSC_LSB  = 2;
	localparam int OSC_MODE_W    = 3;

	// Values after reset, and register write masks.
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [7:0] FLAGS4_MASK  = 8'h03;
	localparam logic [7:0] CTRL_MASK    = 8'h1F;
	localparam logic [7:0] CTRL_RESET   = 8'h02;
	localparam logic [7:0] LIMIT_RESET  = 8'h07;

	// Oscillator modes.
	localparam logic [2:0] OSC_LP    = 3'h0;
	localparam logic [2:0] OSC_XT    = 3'h1;
	localparam logic [2:0] OSC_HS    = 3'h2;
	localparam logic [2:0] OSC_INTRC = 3'h3;

	// Counts of cycles.
	localparam int         OST_W      = 11;
	localparam logic [10:0] OST_CYCLES = 11'h0400;
	localparam int         WDT_W      = 16;
	localparam logic [7:0] WDT_LOW_FULL = 8'hFF;
	localparam logic [13:0] ISR_VECTOR = 14'h0004;
	localparam int         SYNC_N     = 5;

	typedef enum logic [1:0] {SLP_AWAKE, SLP_ASLEEP, SLP_OST} swc_state_t;

	function automatic logic swc_is_crystal(input logic [2:0] mode);
		swc_is_crystal = (mode == OSC_LP) || (mode == OSC_XT) || (mode == OSC_HS);
	endfunction : swc_is_crystal

endpackage : swc_pkg

/* File: include/swc_wdt_if.sv */
// Control and status carried between the sleep controller and its watchdog.
// Both ends run on the core clock.
`timescale 1ns/1ps
interface swc_wdt_if;
	logic       clear;
	logic       run;
	logic       tick;
	logic [7:0] limit;
	logic       timeout;

	modport ctl (output clear, output run, output tick, output limit, input timeout);
	modport wdt (input clear, input run, input tick, input limit, output timeout);
endinterface : swc_wdt_if

/* File: hw/swc_sync.sv */
// Two-stage synchroniser with rising-edge detect for the pin-level inputs.
// Assumes inputs change slowly against the core clock.
`timescale 1ns/1ps
module swc_sync (
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	input  wire logic [swc_pkg::SYNC_N-1:0] async_in,
	output logic      [swc_pkg::SYNC_N-1:0] level_q,
	output logic      [swc_pkg::SYNC_N-1:0] rise_q
);
	// Bit 0 carries the active-low reset pin, so it must come out of reset at its idle
	// high level. Otherwise a false pin reset follows every block reset.
	localparam logic [swc_pkg::SYNC_N-1:0] IDLE_LVL = swc_pkg::SYNC_N'(1);

	logic [swc_pkg::SYNC_N-1:0] meta_q;
	logic [swc_pkg::SYNC_N-1:0] prev_q;
	wire  [swc_pkg::SYNC_N-1:0] rise_d = level_q & ~prev_q;

	// Only the second stage is looked at by the edge detector.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_q  <= IDLE_LVL;
			level_q <= IDLE_LVL;
			prev_q  <= IDLE_LVL;
			rise_q  <= '0;
		end else begin
			meta_q  <= async_in;
			level_q <= meta_q;
			prev_q  <= level_q;
			rise_q  <= rise_d;
		end
	end
endmodule : swc_sync

/* File: hw/swc_watchdog.sv */
// Watchdog counter stepped by low-frequency oscillator ticks.
// Assumes the controller holds clear while the counter must stay at zero.
`timescale 1ns/1ps
module swc_watchdog (
	input  wire logic sys_clk,
	input  wire logic rst,
	swc_wdt_if.wdt    wd
);
	logic [swc_pkg::WDT_W-1:0] cnt_q;
	logic                      timeout_q;
	wire  [swc_pkg::WDT_W-1:0] top_w  = {wd.limit, swc_pkg::WDT_LOW_FULL};
	wire                       step_w = wd.run && wd.tick;
	wire                       hit_w  = step_w && (cnt_q == top_w);
	wire  [swc_pkg::WDT_W-1:0] cnt_d  = (wd.clear || hit_w) ? '0 :
		step_w ? cnt_q + 16'h0001 : cnt_q;

	assign wd.timeout = timeout_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q     <= '0;
			timeout_q <= 1'b0;
		end else begin
			cnt_q     <= cnt_d;
			timeout_q <= hit_w && !wd.clear;
		end
	end
endmodule : swc_watchdog

/* File: hw/swc_sleep_wake_control.sv */
// Sleep entry and wake-up controller for a small processor core.
// Assumes the core pulses sleep_exec and clrwdt_exec for one cycle per
// instruction and honours cpu_clk_en_q, port_hold_q and the resume strobes.
//
// Function
// - Power-down is entered only by the sleep instruction.
// - Entering sleep clears the watchdog; it runs on only if enabled and sleep_run is set.
// - Entering sleep clears power-down flag and sets expiry flag.
// - CPU clock gated in sleep; slow oscillators keep running.
// - Port drive states are held while asleep.
// - Sleep blocks no reset source; watchdog wakes instead of resetting.
// - Pin, brownout, power-on reset fully; watchdog and interrupts resume.
// - The instruction after sleep is prefetched during sleep.
// - Enabled sources wake regardless of the global enable.
// - Global enable clear continues in line, else calls the vector.
// - Every wake clears the watchdog.
// - Pending enabled interrupt makes sleep a no-operation, nothing changes.
// - Interrupt during sleep: complete sleep, wake at once, flags updated.
// - Crystal modes wait 1024 oscillator periods before resuming.
// - Peripheral flags set on their event regardless of enables.
// - Bus collision flag at bit 1, set by hardware, cleared by write.
// - Serial flag at bit 0, set by hardware, cleared by write; upper six bits read zero.
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module swc_sleep_wake_control (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata_q,
	input  wire logic       sleep_exec,
	input  wire logic       clrwdt_exec,
	input  wire logic       global_irq_enable,
	input  wire logic       core_irq_pending,
	input  wire logic       bus_collision_evt,
	input  wire logic       serial_done_evt,
	input  wire logic       master_clear_pin_n,
	input  wire logic       brownout_reset,
	input  wire logic       power_on_reset,
	input  wire logic       lf_osc_clk,
	input  wire logic       ext_osc_clk,
	output logic            cpu_clk_en_q,
	output logic            slow_osc_en_q,
	output logic            port_hold_q,
	output logic            prefetch_q,
	output logic            resume_q,
	output logic            isr_call_q,
	output logic            device_reset_q
);

	swc_pkg::swc_state_t state_q;
	swc_pkg::swc_state_t state_d;

	logic [7:0]           status_q;
	logic [7:0]           status_d;
	logic [7:0]           flags4_q;
	logic [7:0]           enable4_q;
	logic [7:0]           ctrl_q;
	logic [7:0]           limit_q;
	logic [swc_pkg::OST_W-1:0] ost_q;
	logic [swc_pkg::OST_W-1:0] ost_d;
	logic                 irq_cause_q;

	// Pin-level inputs crossing into the core clock domain.
	logic [swc_pkg::SYNC_N-1:0] sync_lvl;
	logic [swc_pkg::SYNC_N-1:0] sync_rise;

	swc_sync u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({ext_osc_clk, lf_osc_clk, power_on_reset,
			brownout_reset, master_clear_pin_n}),
		.level_q  (sync_lvl),
		.rise_q   (sync_rise)
	);

	wire master_clear_pin_lvl   = !sync_lvl[0];
	wire bor_lvl    = sync_lvl[1];
	wire por_lvl    = sync_lvl[2];
	wire lf_tick    = sync_rise[3];
	wire osc_tick   = sync_rise[4];

	// Watchdog.
	swc_wdt_if wd ();

	swc_watchdog u_wdt (
		.sys_clk (sys_clk),
		.rst     (rst),
		.wd      (wd)
	);

	// Register decode.
	wire wr_status = reg_wr && (reg_addr == swc_pkg::REG_STATUS);
	wire wr_flags  = reg_wr && (reg_addr == swc_pkg::REG_FLAGS4);
	wire wr_enable = reg_wr && (reg_addr == swc_pkg::REG_ENABLE4);
	wire wr_ctrl   = reg_wr && (reg_addr == swc_pkg::REG_CTRL);
	wire wr_limit  = reg_wr && (reg_addr == swc_pkg::REG_WDT_LIMIT);

	wire       sleep_run = ctrl_q[swc_pkg::CTRL_SLEEP_RUN];
	wire       wdt_en    = ctrl_q[swc_pkg::CTRL_WDT_EN];
	wire [2:0] osc_mode  = ctrl_q[swc_pkg::CTRL_OSC_LSB +: swc_pkg::OSC_MODE_W];
	wire       crystal   = swc_pkg::swc_is_crystal(osc_mode);

	// Peripheral flag events, independent of any enable.
	wire [7:0] flag_evt = {6'h00, bus_collision_evt, serial_done_evt};

	// A write stores the written bits, but an event in the same cycle wins.
	wire [7:0] flags4_d = ((wr_flags ? reg_wdata : flags4_q) | flag_evt)
		& swc_pkg::FLAGS4_MASK;

	// Wake request from any enabled, pending source; global enable is not used.
	wire wake_req = (|(flags4_q & enable4_q)) || core_irq_pending;

	// Full-device reset sources act in every state.
	wire hard_rst = master_clear_pin_lvl || bor_lvl || por_lvl;
	wire cold_rst = bor_lvl || por_lvl;

	wire awake    = (state_q == swc_pkg::SLP_AWAKE);
	wire asleep   = (state_q == swc_pkg::SLP_ASLEEP);
	wire in_ost   = (state_q == swc_pkg::SLP_OST);

	// Sleep entry only from the sleep instruction, and only with nothing pending.
	wire sleep_go  = awake && sleep_exec && !wake_req && !hard_rst;
	wire sleep_nop = awake && sleep_exec && wake_req;

	// Watchdog expiry wakes while asleep and resets while awake.
	wire wdt_wake  = asleep && wd.timeout && !hard_rst;
	wire irq_wake  = asleep && wake_req && !hard_rst && !wd.timeout;
	wire wake      = wdt_wake || irq_wake;
	wire wdt_rst   = !asleep && wd.timeout;

	wire ost_done  = in_ost && osc_tick && (ost_q == swc_pkg::OST_CYCLES - 11'h001);
	wire resume_d  = (wake && !crystal) || (ost_done && !hard_rst);

	// Watchdog control.
	assign wd.limit = limit_q;
	assign wd.tick  = lf_tick;
	assign wd.run   = wdt_en && (!asleep || sleep_run);
	assign wd.clear = sleep_go || wake || in_ost || clrwdt_exec
		|| hard_rst || !wdt_en;

	// Sleep state machine.
	always_comb begin
		state_d = state_q;
		case (state_q)
			swc_pkg::SLP_AWAKE: begin
				if (sleep_go) begin
					state_d = swc_pkg::SLP_ASLEEP;
				end
			end
			swc_pkg::SLP_ASLEEP: begin
				if (wake) begin
					state_d = crystal ? swc_pkg::SLP_OST : swc_pkg::SLP_AWAKE;
				end
			end
			swc_pkg::SLP_OST: begin
				if (ost_done) begin
					state_d = swc_pkg::SLP_AWAKE;
				end
			end
			default: begin
				state_d = swc_pkg::SLP_AWAKE;
			end
		endcase
		if (hard_rst) begin
			state_d = swc_pkg::SLP_AWAKE;
		end
	end

	// Start-up delay counts oscillator periods seen through the synchroniser.
	always_comb begin
		ost_d = ost_q;
		if (!in_ost) begin
			ost_d = '0;
		end else if (osc_tick) begin
			ost_d = ost_q + 11'h001;
		end
	end

	// Power-down and expiry flags; the stored bits are the documented
	// active-low sense, so a cleared power-down flag means sleep ran.
	always_comb begin
		status_d = status_q;
		if (cold_rst) begin
			status_d = swc_pkg::STATUS_RESET;
		end else if (wdt_rst) begin
			status_d[swc_pkg::BIT_EXPIRY] = 1'b0;
		end else if (sleep_go) begin
			status_d[swc_pkg::BIT_PWRDN]  = 1'b0;
			status_d[swc_pkg::BIT_EXPIRY] = 1'b1;
		end else if (wdt_wake) begin
			status_d[swc_pkg::BIT_EXPIRY] = 1'b0;
			status_d[swc_pkg::BIT_PWRDN]  = 1'b0;
		end else if (irq_wake) begin
			status_d[swc_pkg::BIT_EXPIRY] = 1'b1;
			status_d[swc_pkg::BIT_PWRDN]  = 1'b0;
		end else if (clrwdt_exec && awake) begin
			status_d = swc_pkg::STATUS_RESET;
		end
	end

	// Read multiplexer.
	wire [7:0] rd_mux =
		(reg_addr == swc_pkg::REG_STATUS)    ? status_q  :
		(reg_addr == swc_pkg::REG_FLAGS4)    ? flags4_q  :
		(reg_addr == swc_pkg::REG_ENABLE4)   ? enable4_q :
		(reg_addr == swc_pkg::REG_CTRL)      ? ctrl_q    :
		(reg_addr == swc_pkg::REG_WDT_LIMIT) ? limit_q   : 8'h00;

	// Writes to the status register are ignored; software only reads it.
	wire unused_wr = wr_status;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q     <= swc_pkg::SLP_AWAKE;
			status_q    <= swc_pkg::STATUS_RESET;
			ost_q       <= '0;
		end else begin
			state_q     <= state_d;
			status_q    <= status_d;
			ost_q       <= ost_d;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags4_q    <= 8'h00;
			enable4_q   <= 8'h00;
			ctrl_q      <= swc_pkg::CTRL_RESET;
			limit_q     <= swc_pkg::LIMIT_RESET;
		end else begin
			flags4_q    <= flags4_d;
			if (wr_enable) begin
				enable4_q <= reg_wdata & swc_pkg::FLAGS4_MASK;
			end
			if (wr_ctrl) begin
				ctrl_q <= reg_wdata & swc_pkg::CTRL_MASK;
			end
			if (wr_limit) begin
				limit_q <= reg_wdata;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata_q <= 8'h00;
		end else begin
			reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
		end
	end

	// Remember whether an interrupt caused the wake, for the vector decision.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_cause_q <= 1'b0;
		end else if (wake) begin
			irq_cause_q <= irq_wake;
		end
	end

	// Core-facing strobes and levels.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cpu_clk_en_q   <= 1'b1;
			slow_osc_en_q  <= 1'b1;
			port_hold_q    <= 1'b0;
			prefetch_q     <= 1'b0;
			resume_q       <= 1'b0;
			isr_call_q     <= 1'b0;
			device_reset_q <= 1'b1;
		end else begin
			cpu_clk_en_q   <= (state_d == swc_pkg::SLP_AWAKE);
			slow_osc_en_q  <= 1'b1;
			port_hold_q    <= (state_d != swc_pkg::SLP_AWAKE);
			prefetch_q     <= sleep_go || sleep_nop;
			resume_q       <= resume_d;
			isr_call_q     <= resume_d && global_irq_enable
				&& (in_ost ? irq_cause_q : irq_wake);
			device_reset_q <= hard_rst || wdt_rst;
		end
	end

endmodule : swc_sleep_wake_control

/* File: verification/swc_core_model.sv */
// Behavioural core that issues the sleep instruction for the bench.
// Assumes the bench raises req for one cycle per instruction.
`timescale 1ns/1ps
module swc_core_model (
	input  wire logic sys_clk,
	input  wire logic clk_run,
	input  wire logic req,
	output logic      sleep_exec
);
	initial sleep_exec = 1'b0;
	// A gated core fetches nothing, so a request while stopped is lost.
	always @(posedge sys_clk) begin
		sleep_exec <= req & clk_run;
	end
endmodule : swc_core_model

/* File: verification/swc_sleep_wake_control_chk.sv */
// Concurrent checks on the sleep and wake controller ports.
// Assumes one core clock and the asynchronous active-high block reset.
`timescale 1ns/1ps
module swc_sleep_wake_control_chk (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic [3:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic       sleep_exec,
	input wire logic       global_irq_enable,
	input wire logic       master_clear_pin_n,
	input wire logic       brownout_reset,
	input wire logic       power_on_reset,
	input wire logic       cpu_clk_en_q,
	input wire logic       slow_osc_en_q,
	input wire logic       port_hold_q,
	input wire logic       prefetch_q,
	input wire logic       resume_q,
	input wire logic       isr_call_q,
	input wire logic       device_reset_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_entry_by_instr: assert property (
		$fell(cpu_clk_en_q) |-> $past(sleep_exec) && prefetch_q && port_hold_q)
		else $error("core clock stopped without a sleep instruction");
	a_prefetch_sleep: assert property (
		sleep_exec && cpu_clk_en_q && !device_reset_q |=> prefetch_q)
		else $error("no prefetch after sleep instruction");
	a_hold_gated: assert property (port_hold_q == !cpu_clk_en_q)
		else $error("port hold and clock gate disagree");
	a_slow_osc_on: assert property (slow_osc_en_q)
		else $error("slow oscillator stopped");
	a_resume_rises: assert property (
		resume_q |-> $rose(cpu_clk_en_q) && !port_hold_q)
		else $error("resume without clock restart");
	a_isr_with_gie: assert property (
		isr_call_q |-> resume_q && $past(global_irq_enable))
		else $error("vector call without resume or global enable");
	a_flags_upper_zero: assert property (
		$past(reg_rd && reg_addr == swc_pkg::REG_FLAGS4) |-> reg_rdata_q[7:2] == 6'h00)
		else $error("flag register upper bits not zero");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
		else $error("read data outside read cycle");
	a_reset_pins: assert property (
		!master_clear_pin_n || brownout_reset || power_on_reset |-> ##[1:4] device_reset_q)
		else $error("reset source did not reset device");

	c_isr_wake: cover property (resume_q && isr_call_q);
	c_plain_wake: cover property (resume_q && !isr_call_q);
	c_sleep_noop: cover property (prefetch_q && cpu_clk_en_q);
endmodule : swc_sleep_wake_control_chk

bind swc_sleep_wake_control swc_sleep_wake_control_chk chk (.sys_clk(sys_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .sleep_exec(sleep_exec),
	.global_irq_enable(global_irq_enable), .master_clear_pin_n(master_clear_pin_n),
	.brownout_reset(brownout_reset), .power_on_reset(power_on_reset),
	.cpu_clk_en_q(cpu_clk_en_q), .slow_osc_en_q(slow_osc_en_q), .port_hold_q(port_hold_q),
	.prefetch_q(prefetch_q), .resume_q(resume_q), .isr_call_q(isr_call_q),
	.device_reset_q(device_reset_q));

/* File: verification/swc_sleep_wake_control_tb.sv */
// Self-checking bench for the sleep and wake controller.
// Assumes the core model and checker files are compiled before it.
`timescale 1ns/1ps
module swc_sleep_wake_control_tb;
	typedef struct packed {logic [3:0] a; logic [7:0] d; logic w; logic [7:0] e;} swc_row_t;
	localparam int EXT_CYC = 6;
	logic       sys_clk, rst, reg_wr, reg_rd, sleep_exec, req, clrwdt_exec;
	logic       global_irq_enable, core_irq_pending, bus_collision_evt, serial_done_evt;
	logic       master_clear_pin_n, brownout_reset, power_on_reset, lf_osc_clk, ext_osc_clk;
	logic       cpu_clk_en_q, slow_osc_en_q, port_hold_q, prefetch_q, resume_q;
	logic       isr_call_q, device_reset_q;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata_q;
	int         err_count, total_checks, i, n;
	swc_row_t   rows [11] = '{'{swc_pkg::REG_STATUS, 8'h00, 1'b0, 8'h18},
		'{swc_pkg::REG_FLAGS4, 8'h00, 1'b0, 8'h00}, '{swc_pkg::REG_ENABLE4, 8'h00, 1'b0, 8'h00},
		'{swc_pkg::REG_CTRL, 8'h00, 1'b0, 8'h02}, '{swc_pkg::REG_WDT_LIMIT, 8'h00, 1'b0, 8'h07},
		'{4'h5, 8'hff, 1'b1, 8'h00}, '{swc_pkg::REG_STATUS, 8'h00, 1'b1, 8'h18},
		'{swc_pkg::REG_FLAGS4, 8'hff, 1'b1, 8'h03}, '{swc_pkg::REG_FLAGS4, 8'h00, 1'b1, 8'h00},
		'{swc_pkg::REG_WDT_LIMIT, 8'h00, 1'b1, 8'h00}, '{swc_pkg::REG_CTRL, 8'h0c, 1'b1, 8'h0c}};

	swc_sleep_wake_control uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec), .global_irq_enable(global_irq_enable),
		.core_irq_pending(core_irq_pending), .bus_collision_evt(bus_collision_evt),
		.serial_done_evt(serial_done_evt), .master_clear_pin_n(master_clear_pin_n),
		.brownout_reset(brownout_reset), .power_on_reset(power_on_reset),
		.lf_osc_clk(lf_osc_clk), .ext_osc_clk(ext_osc_clk), .cpu_clk_en_q(cpu_clk_en_q),
		.slow_osc_en_q(slow_osc_en_q), .port_hold_q(port_hold_q), .prefetch_q(prefetch_q),
		.resume_q(resume_q), .isr_call_q(isr_call_q), .device_reset_q(device_reset_q));
	swc_core_model core (.sys_clk(sys_clk), .clk_run(cpu_clk_en_q), .req(req),
		.sleep_exec(sleep_exec));

	always #5 sys_clk = ~sys_clk;
	always #20 lf_osc_clk = ~lf_osc_clk;
	always #30 ext_osc_clk = ~ext_osc_clk;

	task results;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : results
	task chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
		@(posedge sys_clk) reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk) begin reg_addr <= a; reg_rd <= 1'b1; end
		@(posedge sys_clk) reg_rd <= 1'b0;
		#1 chk(16'(reg_rdata_q), 16'(e));
	endtask : rd
	task ev(input logic b, input logic s);
		@(posedge sys_clk) begin bus_collision_evt <= b; serial_done_evt <= s; end
		@(posedge sys_clk) begin bus_collision_evt <= 1'b0; serial_done_evt <= 1'b0; end
	endtask : ev
	task slp;
		@(posedge sys_clk) req <= 1'b1;
		@(posedge sys_clk) req <= 1'b0;
	endtask : slp
	// Bounded wait, so a wake that never comes shows up as a bad count.
	task wres(output int c);
		c = 0;
		while (resume_q !== 1'b1 && c < 8000) begin
			@(posedge sys_clk);
			c++;
		end
	endtask : wres

	initial begin
		#300000 err_count++;
		results();
	end

	initial begin
		{sys_clk, reg_wr, reg_rd, req, clrwdt_exec, global_irq_enable, core_irq_pending} = '0;
		{bus_collision_evt, serial_done_evt, brownout_reset, power_on_reset} = '0;
		{lf_osc_clk, ext_osc_clk, reg_addr, reg_wdata} = '0;
		master_clear_pin_n = 1'b1;
		rst = 1'b1;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		foreach (rows[k]) begin
			if (rows[k].w) wr(rows[k].a, rows[k].d);
			rd(rows[k].a, rows[k].e);
		end
		ev(1'b1, 1'b1);
		rd(swc_pkg::REG_FLAGS4, 8'h03);
		fork wr(swc_pkg::REG_FLAGS4, 8'h00); ev(1'b0, 1'b1); join
		rd(swc_pkg::REG_FLAGS4, 8'h01);
		wr(swc_pkg::REG_FLAGS4, 8'h00);
		wr(swc_pkg::REG_ENABLE4, 8'h01);
		ev(1'b0, 1'b1);
		slp();
		repeat (3) @(posedge sys_clk);
		chk(16'(cpu_clk_en_q), 16'h1);
		rd(swc_pkg::REG_STATUS, 8'h18);
		wr(swc_pkg::REG_FLAGS4, 8'h00);
		for (i = 0; i < 2; i++) begin
			@(posedge sys_clk) global_irq_enable <= i[0];
			slp();
			repeat (3) @(posedge sys_clk);
			chk(16'({cpu_clk_en_q, port_hold_q}), 16'h1);
			rd(swc_pkg::REG_STATUS, 8'h10);
			ev(1'b0, 1'b1);
			wres(n);
			chk(16'({resume_q, isr_call_q}), 16'(2 + i));
			chk(16'(n < 8), 16'h1);
			wr(swc_pkg::REG_FLAGS4, 8'h00);
		end
		wr(swc_pkg::REG_CTRL, 8'h04);
		slp();
		repeat (3) @(posedge sys_clk);
		ev(1'b0, 1'b1);
		wres(n);
		chk(16'(n >= 1023 * EXT_CYC && n <= 1026 * EXT_CYC), 16'h1);
		wr(swc_pkg::REG_FLAGS4, 8'h00);
		// Watchdog runs awake first; entry must restart its full 256-tick span.
		wr(swc_pkg::REG_CTRL, 8'h0f);
		repeat (500) @(posedge sys_clk);
		slp();
		wres(n);
		chk(16'(n > 1008 && n < 1040), 16'h1);
		chk(16'(device_reset_q), 16'h0);
		wr(swc_pkg::REG_CTRL, 8'h0c);
		rd(swc_pkg::REG_STATUS, 8'h00);
		slp();
		for (i = 0; i < 3; i++) begin
			repeat (3) @(posedge sys_clk);
			master_clear_pin_n <= (i != 0);
			brownout_reset <= (i == 1);
			power_on_reset <= (i == 2);
			repeat (6) @(posedge sys_clk);
			chk(16'({device_reset_q, cpu_clk_en_q, port_hold_q}), 16'h6);
			master_clear_pin_n <= 1'b1;
			brownout_reset <= 1'b0;
			power_on_reset <= 1'b0;
		end
		repeat (6) @(posedge sys_clk);
		rd(swc_pkg::REG_STATUS, 8'h18);
		results();
	end
endmodule : swc_sleep_wake_control_tb
